// ===== fcec_pkg.sv
// Shared constants and types for the four channel event counter controller
package fcec_pkg;

  localparam int NCH   = 4;
  localparam int CNT_W = 32;
  localparam int AW    = 8;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_ZERO    = 8'h00;
  localparam logic [AW-1:0] OFS_RUN     = 8'h04;
  localparam logic [AW-1:0] OFS_DIFF    = 8'h08;
  localparam logic [AW-1:0] OFS_IRQ_ST  = 8'h0c;
  localparam logic [AW-1:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [AW-1:0] OFS_IRQ_EN  = 8'h14;
  localparam logic [AW-1:0] OFS_MODE    = 8'h20;
  localparam logic [AW-1:0] OFS_STATUS  = 8'h30;
  localparam logic [AW-1:0] OFS_COUNT   = 8'h40;
  localparam logic [AW-1:0] OFS_PW      = 8'h50;

  // Run control field positions
  localparam int RUN_STD_LSB = 0;
  localparam int RUN_PW_LSB  = 8;
  localparam int RUN_W       = 12;
  localparam logic [RUN_W-1:0] RUN_MASK = 12'hf0f;

  // Counter mode field positions
  localparam int MD_AB    = 0;
  localparam int MD_CLRAB = 1;
  localparam int MD_INVA  = 2;
  localparam int MD_INVB  = 3;
  localparam int MD_LATCH = 4;
  localparam int MD_CLREN = 5;
  localparam int MD_W     = 6;

  // Status field positions
  localparam int ST_A    = 0;
  localparam int ST_B    = 1;
  localparam int ST_ZIN  = 2;
  localparam int ST_LINE = 3;
  localparam int ST_CORR = 4;
  localparam int ST_W    = 5;

  // Interrupt status layout: line errors low, correlation errors high
  localparam int IRQ_LINE_LSB = 0;
  localparam int IRQ_CORR_LSB = 4;
  localparam int IRQ_W        = 8;

  // Reset values
  localparam logic [RUN_W-1:0] RUN_RST  = 12'h000;
  localparam logic [MD_W-1:0]  MODE_RST = 6'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic a;
    logic b;
    logic zin;
    logic fault;
  } fcec_pin_s;

  typedef struct packed {
    logic             a_q;
    logic             b_q;
    logic [CNT_W-1:0] cnt;
    logic             line;
    logic             corr;
  } fcec_ch_s;

  typedef struct packed {
    logic [NCH-1:0]                zsel;
    logic [RUN_W-1:0]              run;
    logic [NCH-1:0]                diff;
    logic [IRQ_W-1:0]              irq_st;
    logic [IRQ_W-1:0]              irq_en;
    logic [NCH-1:0][MD_W-1:0]      mode;
    logic [NCH-1:0][CNT_W-1:0]     pw;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
  } fcec_top_s;

endpackage

// ===== fcec_chan.sv
// One standard event counter with its status flags
`timescale 1ns/1ps
`default_nettype none
module fcec_chan #(
  parameter int CW = fcec_pkg::CNT_W
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire fcec_pkg::fcec_pin_s          pin,
  input  wire logic [fcec_pkg::MD_W-1:0]    mode,
  input  wire logic                         run,
  input  wire logic                         zero_cmd,
  input  wire logic                         diff,
  input  wire logic                         st_rd,
  output logic [fcec_pkg::CNT_W-1:0]        count,
  output logic [fcec_pkg::ST_W-1:0]         status,
  output logic                              line_evt,
  output logic                              corr_evt
);

  initial begin
    if (CW != fcec_pkg::CNT_W) begin
      $error("fcec_chan: CW must equal package counter width");
    end
  end

  fcec_pkg::fcec_ch_s st_r;
  fcec_pkg::fcec_ch_s st_nxt;

  logic a_i;
  logic b_i;
  logic ab_mode;
  logic clr_and;
  logic step;
  logic up;
  logic zero_ok;
  logic pin_clr;

  always_comb begin
    a_i      = pin.a ^ mode[fcec_pkg::MD_INVA];
    b_i      = pin.b ^ mode[fcec_pkg::MD_INVB];
    ab_mode  = mode[fcec_pkg::MD_AB];
    clr_and  = mode[fcec_pkg::MD_CLRAB] & ab_mode;
    // Both lines moving together means no phase offset
    corr_evt = ab_mode & (a_i != st_r.a_q) & (b_i != st_r.b_q);
    line_evt = diff & pin.fault;
    if (ab_mode) begin
      step = (a_i ^ st_r.a_q) ^ (b_i ^ st_r.b_q);
      up   = st_r.a_q ^ b_i;
    end else begin
      step = a_i & ~st_r.a_q;
      up   = ~b_i;
    end
    zero_ok = zero_cmd & (~clr_and | (pin.a & pin.b));
    pin_clr = mode[fcec_pkg::MD_CLREN] & ~mode[fcec_pkg::MD_LATCH] &
              pin.zin & (~clr_and | (pin.a & pin.b));
    st_nxt     = st_r;
    st_nxt.a_q = a_i;
    st_nxt.b_q = b_i;
    if (zero_ok | pin_clr) begin
      st_nxt.cnt = '0;
    end else if (run & step) begin
      st_nxt.cnt = up ? st_r.cnt + 1'b1 : st_r.cnt - 1'b1;
    end
    // Stopped counter keeps its value unless zeroed or cleared from the pin
    // A new error in the read cycle survives the clear
    st_nxt.line = (st_r.line & ~st_rd) | line_evt;
    st_nxt.corr = (st_r.corr & ~st_rd) | corr_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign count  = st_r.cnt;
  assign status = {st_r.corr, st_r.line & diff, pin.zin, pin.b, pin.a};

endmodule
`default_nettype wire

// ===== fcec_top.sv
// Four channel event counter controller with AXI4-Lite registers
//
// Notes on behaviour
// - A zeroing pattern clears each counter whose bit 0..3 is set (in A-B clear mode only while A and B are high); bits above 3 are ignored.
// - The zeroing pattern returns to zero by itself once applied, and counters resume from zero.
// - A zero in run bits 0..3 or 8..11 stops that standard or pulse-width counter.
// - A one in those run bits lets the counter count; bits 4..7 do nothing.
// - Standard and pulse-width groups start and stop independently.
// - Status bits 0,1,2 show the live levels of A, B and the clear input.
// - Status bit 3 flags a line error on the counter's inputs.
// - Line errors are only seen on differential inputs; otherwise bit 3 reads zero.
// - Status bit 4 flags A and B changing together in A-B mode, a correlation error.
// - Status bits 5..31 carry no meaning and the reader masks them off.
// - Reading a status register clears its error flags.
// - Clear-mode bit 1 set in A-B mode needs A, B and the clear input all high to clear.
// - With the clear input enabled, latch bit 4 low and standard clear mode, a high input holds the count at zero.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fcec_top #(
  parameter int NCH = fcec_pkg::NCH
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  input  wire logic [fcec_pkg::AW-1:0]         s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [fcec_pkg::AW-1:0]         s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire fcec_pkg::fcec_pin_s [3:0]       pins,
  output logic                                 irq
);

  initial begin
    if (NCH != fcec_pkg::NCH) begin
      $error("fcec_top: exactly four channels are supported");
    end
  end

  // True when addr hits the single word at base
  function automatic logic fcec_word(
    input logic [fcec_pkg::AW-1:0] addr,
    input logic [fcec_pkg::AW-1:0] base
  );
    fcec_word = (addr[fcec_pkg::AW-1:2] == base[fcec_pkg::AW-1:2]);
  endfunction

  // True when addr hits the four-word group at base
  function automatic logic fcec_grp(
    input logic [fcec_pkg::AW-1:0] addr,
    input logic [fcec_pkg::AW-1:0] base
  );
    fcec_grp = (addr[fcec_pkg::AW-1:4] == base[fcec_pkg::AW-1:4]);
  endfunction

  fcec_pkg::fcec_top_s st_r;
  fcec_pkg::fcec_top_s st_nxt;

  logic                                  wr_go;
  logic                                  rd_go;
  logic [1:0]                            wr_idx;
  logic [1:0]                            rd_idx;
  logic [3:0]                            st_rd;
  logic [3:0][fcec_pkg::CNT_W-1:0]       cnt;
  logic [3:0][fcec_pkg::ST_W-1:0]        stat;
  logic [3:0]                            line_evt;
  logic [3:0]                            corr_evt;
  logic [fcec_pkg::IRQ_W-1:0]            irq_set;
  logic [31:0]                           wmask;
  logic                                  wr_ok;
  logic                                  rd_ok;
  logic [31:0]                           rd_val;

  // One write and one read at a time; both halves taken together
  assign wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~st_r.bvalid;
  assign rd_go = ce & s_axi_arvalid & ~st_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = st_r.rdata;

  assign wr_idx = s_axi_awaddr[3:2];
  assign rd_idx = s_axi_araddr[3:2];

  // Status read clears flags only when the read is really taken
  always_comb begin
    st_rd = '0;
    if (rd_go & fcec_grp(s_axi_araddr, fcec_pkg::OFS_STATUS)) begin
      st_rd[rd_idx] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      fcec_chan #(
        .CW       (fcec_pkg::CNT_W)
      ) u_chan (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin      (pins[gi]),
        .mode     (st_r.mode[gi]),
        .run      (st_r.run[fcec_pkg::RUN_STD_LSB+gi]),
        .zero_cmd (st_r.zsel[gi]),
        .diff     (st_r.diff[gi]),
        .st_rd    (st_rd[gi]),
        .count    (cnt[gi]),
        .status   (stat[gi]),
        .line_evt (line_evt[gi]),
        .corr_evt (corr_evt[gi])
      );
    end
  endgenerate

  assign irq_set = {corr_evt, line_evt};

  // Byte lanes of the write
  always_comb begin
    wmask = '0;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  // Write address decode
  always_comb begin
    wr_ok = fcec_word(s_axi_awaddr, fcec_pkg::OFS_ZERO)    |
            fcec_word(s_axi_awaddr, fcec_pkg::OFS_RUN)     |
            fcec_word(s_axi_awaddr, fcec_pkg::OFS_DIFF)    |
            fcec_word(s_axi_awaddr, fcec_pkg::OFS_IRQ_CLR) |
            fcec_word(s_axi_awaddr, fcec_pkg::OFS_IRQ_EN)  |
            fcec_grp(s_axi_awaddr, fcec_pkg::OFS_MODE);
  end

  // Read mux; write-only words read as zero
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    if (fcec_word(s_axi_araddr, fcec_pkg::OFS_ZERO)) begin
      rd_val = 32'(st_r.zsel);
    end else if (fcec_word(s_axi_araddr, fcec_pkg::OFS_RUN)) begin
      rd_val = '0;
    end else if (fcec_word(s_axi_araddr, fcec_pkg::OFS_DIFF)) begin
      rd_val = 32'(st_r.diff);
    end else if (fcec_word(s_axi_araddr, fcec_pkg::OFS_IRQ_ST)) begin
      rd_val = 32'(st_r.irq_st);
    end else if (fcec_word(s_axi_araddr, fcec_pkg::OFS_IRQ_CLR)) begin
      rd_val = '0;
    end else if (fcec_word(s_axi_araddr, fcec_pkg::OFS_IRQ_EN)) begin
      rd_val = 32'(st_r.irq_en);
    end else if (fcec_grp(s_axi_araddr, fcec_pkg::OFS_MODE)) begin
      rd_val = 32'(st_r.mode[rd_idx]);
    end else if (fcec_grp(s_axi_araddr, fcec_pkg::OFS_STATUS)) begin
      // Upper bits forced to zero
      rd_val = 32'(stat[rd_idx]);
    end else if (fcec_grp(s_axi_araddr, fcec_pkg::OFS_COUNT)) begin
      rd_val = 32'(cnt[rd_idx]);
    end else if (fcec_grp(s_axi_araddr, fcec_pkg::OFS_PW)) begin
      rd_val = 32'(st_r.pw[rd_idx]);
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;

    // Zeroing pattern is applied for one cycle then drops
    st_nxt.zsel = '0;

    // Pulse-width counters: cycles while input A is high
    for (int i = 0; i < 4; i++) begin
      if (st_r.run[fcec_pkg::RUN_PW_LSB+i] & pins[i].a) begin
        st_nxt.pw[i] = st_r.pw[i] + 1'b1;
      end
    end

    // Response handshakes
    if (st_r.bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Interrupt clear first so a same-cycle event wins
    if (wr_go & fcec_word(s_axi_awaddr, fcec_pkg::OFS_IRQ_CLR)) begin
      st_nxt.irq_st = st_r.irq_st &
                      ~(s_axi_wdata[fcec_pkg::IRQ_W-1:0] &
                        wmask[fcec_pkg::IRQ_W-1:0]);
    end
    st_nxt.irq_st = st_nxt.irq_st | irq_set;

    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_ok ? fcec_pkg::RESP_OKAY : fcec_pkg::RESP_SLVERR;
      if (fcec_word(s_axi_awaddr, fcec_pkg::OFS_ZERO) & s_axi_wstrb[0]) begin
        // Only bits 0..3 select counters
        st_nxt.zsel = s_axi_wdata[3:0];
      end
      if (fcec_word(s_axi_awaddr, fcec_pkg::OFS_RUN)) begin
        // Bits 4..7 are dropped by the mask
        st_nxt.run = (st_r.run & ~wmask[fcec_pkg::RUN_W-1:0]) |
                     (s_axi_wdata[fcec_pkg::RUN_W-1:0] &
                      wmask[fcec_pkg::RUN_W-1:0] &
                      fcec_pkg::RUN_MASK);
      end
      if (fcec_word(s_axi_awaddr, fcec_pkg::OFS_DIFF) & s_axi_wstrb[0]) begin
        st_nxt.diff = s_axi_wdata[3:0];
      end
      if (fcec_word(s_axi_awaddr, fcec_pkg::OFS_IRQ_EN) & s_axi_wstrb[0]) begin
        st_nxt.irq_en = s_axi_wdata[fcec_pkg::IRQ_W-1:0];
      end
      if (fcec_grp(s_axi_awaddr, fcec_pkg::OFS_MODE) & s_axi_wstrb[0]) begin
        // Mode should only change while the counter is stopped
        st_nxt.mode[wr_idx] = s_axi_wdata[fcec_pkg::MD_W-1:0];
      end
    end

    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_ok ? fcec_pkg::RESP_OKAY : fcec_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.run  <= fcec_pkg::RUN_RST;
      st_r.mode <= {4{fcec_pkg::MODE_RST}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Level interrupt: any enabled sticky event
  assign irq = |(st_r.irq_st & st_r.irq_en);

endmodule
`default_nettype wire

// ===== fcec_top_assertions.sv
// Bus and status checks bound to the counter controller top
`timescale 1ns/1ps
`default_nettype none
module fcec_top_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  logic st_rd_r;
  logic hi_rd_r;
  // Class of the read in flight, kept until the next read is taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_rd_r <= 1'b0;
      hi_rd_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      st_rd_r <= (s_axi_araddr[7:4] == 4'h3);
      hi_rd_r <= (s_axi_araddr >= 8'h60);
    end
  end
  a_wr_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  a_rd_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_status_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && st_rd_r |-> s_axi_rdata[31:5] == 27'h0)
    else $error("status upper bits not zero");
  a_unmapped_rd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && hi_rd_r |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_idle: assert property (@(posedge clk_sys)
    !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy after reset");
endmodule
bind fcec_top fcec_top_assertions u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ===== fcec_enc_model.sv
// Pulse source and line model for the four counter inputs
`timescale 1ns/1ps
`default_nettype none
module fcec_enc_model (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           pulse,
  input  wire logic [3:0]           hold_ab,
  input  wire logic [3:0]           zin_lvl,
  input  wire logic [3:0]           brk,
  output var fcec_pkg::fcec_pin_s [3:0] pins
);
  logic [3:0] clk_r;
  // Registered so the pins move just after an edge, like a real driver
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_r <= 4'h0;
    end else begin
      clk_r <= pulse;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins[i].a     = hold_ab[i] | clk_r[i];
      pins[i].b     = hold_ab[i];
      pins[i].zin   = zin_lvl[i];
      pins[i].fault = brk[i];
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the four channel event counter controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] pulse, hold_ab, zin_lvl, brk;
  fcec_pkg::fcec_pin_s [3:0] pins;
  int fails = 0, tests_run = 0, cyc = 0;
  fcec_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins), .irq(irq));
  fcec_enc_model enc (.clk_sys(clk_sys), .rst_n(rst_n), .pulse(pulse),
    .hold_ab(hold_ab), .zin_lvl(zin_lvl), .brk(brk), .pins(pins));
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A late answer taker keeps the response standing for a few cycles
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input int late = 0);
    @(posedge clk_sys);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (late == 0);
    #1;
    while (!awready) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    #1;
    while (!bvalid) begin
      @(posedge clk_sys);
      #1;
    end
    if (late > 0) begin
      repeat (late) @(posedge clk_sys);
      bready <= 1'b1;
      #1;
    end
    resp = bresp;
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input int late = 0);
    @(posedge clk_sys);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= (late == 0);
    #1;
    while (!arready) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    arvalid <= 1'b0;
    #1;
    while (!rvalid) begin
      @(posedge clk_sys);
      #1;
    end
    if (late > 0) begin
      repeat (late) @(posedge clk_sys);
      rready <= 1'b1;
      #1;
    end
    resp = rresp;
    data = rdata;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  // Masked compare; status reads always drop the undefined upper bits
  task automatic rdc(input string nm, input logic [7:0] ad,
                     input logic [31:0] m, input logic [31:0] e);
    rd(ad);
    chk(nm, e, data & m);
  endtask
  task automatic pulse_n(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pulse <= m;
      @(posedge clk_sys);
      pulse <= 4'h0;
    end
  endtask
  task automatic cnt4(input logic [31:0] e0, e1, e2, e3);
    logic [31:0] e [4];
    e = '{e0, e1, e2, e3};
    for (int i = 0; i < 4; i++)
      rdc("count", fcec_pkg::OFS_COUNT + 8'(4 * i), 32'hffffffff, e[i]);
  endtask
  task automatic t_regs;
    wr(8'h60, 32'h1, 2);
    chk("bresp unmapped", fcec_pkg::RESP_SLVERR, 32'(resp));
    rd(8'h64);
    chk("rresp high", fcec_pkg::RESP_SLVERR, 32'(resp));
    chk("rdata high", 32'h0, data);
    wr(fcec_pkg::OFS_IRQ_ST, 32'hff);
    chk("bresp read-only", fcec_pkg::RESP_SLVERR, 32'(resp));
    rd(8'h18);
    chk("rresp unmapped", fcec_pkg::RESP_SLVERR, 32'(resp));
    wr(fcec_pkg::OFS_DIFF, 32'h5);
    rdc("diff", fcec_pkg::OFS_DIFF, 32'hf, 32'h5);
    rd(fcec_pkg::OFS_DIFF, 2);
    chk("diff late", 32'h5, data);
    $display("test regs done");
  endtask
  task automatic t_zero;
    wr(fcec_pkg::OFS_RUN, 32'hf);
    pulse_n(4'hf, 3);
    cnt4(3, 3, 3, 3);
    wr(fcec_pkg::OFS_RUN, 32'h0);
    pulse_n(4'hf, 2);
    cnt4(3, 3, 3, 3);
    wr(fcec_pkg::OFS_ZERO, 32'hfffffff5);
    rdc("zero sel", fcec_pkg::OFS_ZERO, 32'hffffffff, 32'h0);
    cnt4(0, 3, 0, 3);
    wr(fcec_pkg::OFS_RUN, 32'hf);
    pulse_n(4'h1, 1);
    cnt4(1, 3, 0, 3);
    $display("test zero done");
  endtask
  task automatic t_groups;
    wr(fcec_pkg::OFS_RUN, 32'h100);
    @(posedge clk_sys);
    pulse <= 4'h1;
    repeat (5) @(posedge clk_sys);
    pulse <= 4'h0;
    rdc("pw1", fcec_pkg::OFS_PW, 32'hffffffff, 32'h5);
    cnt4(1, 3, 0, 3);
    wr(fcec_pkg::OFS_RUN, 32'h0f0);
    pulse_n(4'hf, 2);
    cnt4(1, 3, 0, 3);
    rdc("pw1", fcec_pkg::OFS_PW, 32'hffffffff, 32'h5);
    $display("test groups done");
  endtask
  task automatic t_pinclr;
    wr(fcec_pkg::OFS_RUN, 32'h2);
    wr(fcec_pkg::OFS_MODE + 8'h4, 32'h20);
    zin_lvl <= 4'h2;
    pulse_n(4'h2, 2);
    cnt4(1, 0, 0, 3);
    zin_lvl <= 4'h0;
    pulse_n(4'h2, 1);
    cnt4(1, 1, 0, 3);
    wr(fcec_pkg::OFS_MODE + 8'hc, 32'h23);
    zin_lvl <= 4'h8;
    cnt4(1, 1, 0, 3);
    hold_ab <= 4'h8;
    cnt4(1, 1, 0, 0);
    zin_lvl <= 4'h0;
    $display("test pin clear done");
  endtask
  task automatic t_status;
    brk <= 4'h3;
    zin_lvl <= 4'h1;
    wr(fcec_pkg::OFS_DIFF, 32'h1);
    wr(fcec_pkg::OFS_IRQ_EN, 32'h1);
    chk("irq", 1, 32'(irq));
    wr(fcec_pkg::OFS_IRQ_EN, 32'h0);
    chk("irq masked", 0, 32'(irq));
    wr(fcec_pkg::OFS_IRQ_EN, 32'h1);
    brk <= 4'h0;
    rdc("irq st", fcec_pkg::OFS_IRQ_ST, 32'h1, 32'h1);
    rdc("st1", fcec_pkg::OFS_STATUS, 32'h1f, 32'h0c);
    rdc("st2", fcec_pkg::OFS_STATUS + 8'h4, 32'h1f, 32'h0);
    rdc("st1", fcec_pkg::OFS_STATUS, 32'h1f, 32'h04);
    rdc("st4", fcec_pkg::OFS_STATUS + 8'hc, 32'h1f, 32'h13);
    rdc("st4", fcec_pkg::OFS_STATUS + 8'hc, 32'h1f, 32'h03);
    wr(fcec_pkg::OFS_IRQ_CLR, 32'hff);
    chk("irq cleared", 0, 32'(irq));
    $display("test status done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {pulse, hold_ab, zin_lvl, brk} = 16'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_zero();
    t_groups();
    t_pinclr();
    t_status();
    final_report();
  end
endmodule
`default_nettype wire
